// >>> rtl/motion_pkg.sv
package motion_pkg;

    // Register port and field widths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int LEVEL_W = 11;
    localparam int QUEUE_W = 10;
    localparam int STILL_DWELL_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] QUEUE_COUNT_LOW_OFS = 6'h0c;
    localparam logic [ADDR_W-1:0] QUEUE_COUNT_HIGH_OFS = 6'h0d;
    localparam logic [ADDR_W-1:0] X_SAMPLE_LOW_OFS = 6'h0e;
    localparam logic [ADDR_W-1:0] X_SAMPLE_HIGH_OFS = 6'h0f;
    localparam logic [ADDR_W-1:0] Y_SAMPLE_LOW_OFS = 6'h10;
    localparam logic [ADDR_W-1:0] Y_SAMPLE_HIGH_OFS = 6'h11;
    localparam logic [ADDR_W-1:0] Z_SAMPLE_LOW_OFS = 6'h12;
    localparam logic [ADDR_W-1:0] Z_SAMPLE_HIGH_OFS = 6'h13;
    localparam logic [ADDR_W-1:0] THERMAL_SAMPLE_LOW_OFS = 6'h14;
    localparam logic [ADDR_W-1:0] THERMAL_SAMPLE_HIGH_OFS = 6'h15;
    localparam logic [ADDR_W-1:0] SOFTWARE_RESET_KEY_OFS = 6'h1f;
    localparam logic [ADDR_W-1:0] MOTION_LEVEL_LOW_OFS = 6'h20;
    localparam logic [ADDR_W-1:0] MOTION_LEVEL_HIGH_OFS = 6'h21;
    localparam logic [ADDR_W-1:0] MOTION_DWELL_OFS = 6'h22;
    localparam logic [ADDR_W-1:0] STILLNESS_LEVEL_LOW_OFS = 6'h23;
    localparam logic [ADDR_W-1:0] STILLNESS_LEVEL_HIGH_OFS = 6'h24;
    localparam logic [ADDR_W-1:0] STILLNESS_DWELL_LOW_OFS = 6'h25;
    localparam logic [ADDR_W-1:0] STILLNESS_DWELL_HIGH_OFS = 6'h26;

    // Field positions
    localparam int SIGN_BIT_POS = 11;
    localparam int LEVEL_HIGH_BITS = 3;
    localparam int QUEUE_HIGH_BITS = 2;

    // Keys and reset values
    localparam logic [DATA_W-1:0] SOFT_RESET_KEY = 8'h52;
    localparam logic [DATA_W-1:0] SOFT_RESET_READ_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] CONFIG_RESET_VALUE = 8'h00;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET_VALUE = 12'h000;
    localparam logic [QUEUE_W-1:0] QUEUE_RESET_VALUE = 10'h000;

    // Host wait after a keyed reset
    localparam int SOFT_RESET_SETTLE_NS = 500000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SOFT_RESET_SETTLE_CYCLES = SOFT_RESET_SETTLE_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/motion_data_and_detect_regs.sv
`timescale 1ns/100ps
// Behaviour
// - Queue count 0..512, low byte plus two bits
// - X sample 12-bit, high byte sign filled
// - Y sample 12-bit, high byte sign filled
// - Z sample 12-bit, high byte sign filled
// - Temperature 12-bit, high nibble follows bit 11
// - Key 0x52 clears settings, enters standby
// - After keyed reset interrupt pins float
// - Reset key register reads as 0x00
// - Activity compares axis magnitude to 11-bit level
// - Levels built from low byte, three high bits
// - Activity after dwell consecutive above-level samples
// - Activity dwell zero acts as one
// - Wake-up mode uses single sample for activity
// - Inactivity compares axis magnitude to 11-bit level
// - Inactivity after 16-bit dwell consecutive quiet samples
// - Inactivity dwell from low and high bytes
// - Inactivity dwell zero acts as one
// - Levels are raw codes, range independent
module motion_data_and_detect_regs
    import motion_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Register port from the serial front end
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic [DATA_W-1:0]        wr_data,
    output logic      [DATA_W-1:0]        rd_data,
    // Sample source, same clock
    input  wire logic                     sample_strobe,
    input  wire logic [SAMPLE_W-1:0]      x_sample,
    input  wire logic [SAMPLE_W-1:0]      y_sample,
    input  wire logic [SAMPLE_W-1:0]      z_sample,
    input  wire logic [SAMPLE_W-1:0]      thermal_sample,
    input  wire logic [QUEUE_W-1:0]       queue_count,
    // Detector control from neighbouring logic
    input  wire logic                     motion_enable,
    input  wire logic                     stillness_enable,
    input  wire logic                     wakeup_mode,
    input  wire logic                     int_pins_claim,
    // Events and status
    output logic                          motion_event,
    output logic                          stillness_event,
    output logic                          soft_reset_pulse,
    output logic                          standby,
    output logic                          int_pins_oe_n
);

    typedef struct packed {
        logic [DATA_W-1:0]        rd_data;
        logic [QUEUE_W-1:0]       queue;
        logic [SAMPLE_W-1:0]      x;
        logic [SAMPLE_W-1:0]      y;
        logic [SAMPLE_W-1:0]      z;
        logic [SAMPLE_W-1:0]      thermal;
        logic [DATA_W-1:0]        motion_level_low;
        logic [LEVEL_HIGH_BITS-1:0] motion_level_high;
        logic [DATA_W-1:0]        motion_dwell;
        logic [DATA_W-1:0]        stillness_level_low;
        logic [LEVEL_HIGH_BITS-1:0] stillness_level_high;
        logic [DATA_W-1:0]        stillness_dwell_low;
        logic [DATA_W-1:0]        stillness_dwell_high;
        logic [DATA_W-1:0]        motion_dwell_count;
        logic [STILL_DWELL_W-1:0] stillness_dwell_count;
        logic                     motion_event;
        logic                     stillness_event;
        logic                     soft_reset_pulse;
        logic                     standby;
        logic                     int_pins_oe_n;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // Magnitude of a signed code; -2048 gives 2048, which still fits 12 bits
    function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] m;
        m = s[SIGN_BIT_POS] ? SAMPLE_W'(~s + 12'h001) : s;
        return m;
    endfunction

    // Upper result byte with sign fill
    function automatic logic [DATA_W-1:0] high_byte(input logic [SAMPLE_W-1:0] s);
        logic [DATA_W-1:0] b;
        b = {{4{s[SIGN_BIT_POS]}}, s[SIGN_BIT_POS:8]};
        return b;
    endfunction

    // Level and axis magnitude vectors
    logic [LEVEL_W-1:0]  motion_level;
    logic [LEVEL_W-1:0]  stillness_level;
    logic [2:0]          axis_above;
    logic [2:0]          axis_below;
    logic [SAMPLE_W-1:0] axis_sample [3];

    assign axis_sample[0] = x_sample;
    assign axis_sample[1] = y_sample;
    assign axis_sample[2] = z_sample;

    assign motion_level = {state_reg.motion_level_high, state_reg.motion_level_low};
    assign stillness_level = {state_reg.stillness_level_high, state_reg.stillness_level_low};

    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign axis_above[i] = magnitude(axis_sample[i]) > {1'b0, motion_level};
        assign axis_below[i] = magnitude(axis_sample[i]) < {1'b0, stillness_level};
    end

    always_comb begin
        logic [DATA_W-1:0]        motion_need;
        logic [STILL_DWELL_W-1:0] stillness_need;
        logic [STILL_DWELL_W-1:0] stillness_dwell;
        motion_need = 8'h00;
        stillness_need = 16'h0000;
        stillness_dwell = 16'h0000;
        state_next = state_reg;
        state_next.motion_event = 1'b0;
        state_next.stillness_event = 1'b0;
        state_next.soft_reset_pulse = 1'b0;

        motion_need = (wakeup_mode || state_reg.motion_dwell == 8'h00) ? 8'h01 : state_reg.motion_dwell;
        stillness_dwell = {state_reg.stillness_dwell_high, state_reg.stillness_dwell_low};
        stillness_need = (stillness_dwell == 16'h0000) ? 16'h0001 : stillness_dwell;

        state_next.queue = queue_count;

        if (sample_strobe) begin
            state_next.x = x_sample;
            state_next.y = y_sample;
            state_next.z = z_sample;
            state_next.thermal = thermal_sample;

            // activity run, pulse once on reaching dwell
            if (motion_enable && |axis_above) begin
                if (state_reg.motion_dwell_count < motion_need) begin
                    state_next.motion_dwell_count = state_reg.motion_dwell_count + 8'h01;
                    state_next.motion_event = (state_reg.motion_dwell_count + 8'h01) == motion_need;
                end
            end else begin
                state_next.motion_dwell_count = 8'h00;
            end

            if (stillness_enable && &axis_below) begin
                if (state_reg.stillness_dwell_count < stillness_need) begin
                    state_next.stillness_dwell_count = state_reg.stillness_dwell_count + 16'h0001;
                    state_next.stillness_event = (state_reg.stillness_dwell_count + 16'h0001) == stillness_need;
                end
            end else begin
                state_next.stillness_dwell_count = 16'h0000;
            end
        end

        // Interrupt pins are claimed back once mapping logic asks
        if (int_pins_claim) begin
            state_next.int_pins_oe_n = 1'b0;
        end

        // Read path, registered one cycle after rd_en
        if (rd_en) begin
            case (addr)
                QUEUE_COUNT_LOW_OFS:      state_next.rd_data = state_reg.queue[7:0];
                QUEUE_COUNT_HIGH_OFS:     state_next.rd_data = {6'h00, state_reg.queue[QUEUE_W-1:8]};
                X_SAMPLE_LOW_OFS:         state_next.rd_data = state_reg.x[7:0];
                X_SAMPLE_HIGH_OFS:        state_next.rd_data = high_byte(state_reg.x);
                Y_SAMPLE_LOW_OFS:         state_next.rd_data = state_reg.y[7:0];
                Y_SAMPLE_HIGH_OFS:        state_next.rd_data = high_byte(state_reg.y);
                Z_SAMPLE_LOW_OFS:         state_next.rd_data = state_reg.z[7:0];
                Z_SAMPLE_HIGH_OFS:        state_next.rd_data = high_byte(state_reg.z);
                THERMAL_SAMPLE_LOW_OFS:   state_next.rd_data = state_reg.thermal[7:0];
                THERMAL_SAMPLE_HIGH_OFS:  state_next.rd_data = high_byte(state_reg.thermal);
                SOFTWARE_RESET_KEY_OFS:   state_next.rd_data = SOFT_RESET_READ_VALUE;
                MOTION_LEVEL_LOW_OFS:     state_next.rd_data = state_reg.motion_level_low;
                MOTION_LEVEL_HIGH_OFS:    state_next.rd_data = {5'h00, state_reg.motion_level_high};
                MOTION_DWELL_OFS:         state_next.rd_data = state_reg.motion_dwell;
                STILLNESS_LEVEL_LOW_OFS:  state_next.rd_data = state_reg.stillness_level_low;
                STILLNESS_LEVEL_HIGH_OFS: state_next.rd_data = {5'h00, state_reg.stillness_level_high};
                STILLNESS_DWELL_LOW_OFS:  state_next.rd_data = state_reg.stillness_dwell_low;
                STILLNESS_DWELL_HIGH_OFS: state_next.rd_data = state_reg.stillness_dwell_high;
                default:                  state_next.rd_data = UNMAPPED_READ_VALUE;
            endcase
        end

        // Configuration writes; read-only offsets ignore writes
        if (wr_en) begin
            case (addr)
                MOTION_LEVEL_LOW_OFS:     state_next.motion_level_low = wr_data;
                MOTION_LEVEL_HIGH_OFS:    state_next.motion_level_high = wr_data[LEVEL_HIGH_BITS-1:0];
                MOTION_DWELL_OFS:         state_next.motion_dwell = wr_data;
                STILLNESS_LEVEL_LOW_OFS:  state_next.stillness_level_low = wr_data;
                STILLNESS_LEVEL_HIGH_OFS: state_next.stillness_level_high = wr_data[LEVEL_HIGH_BITS-1:0];
                STILLNESS_DWELL_LOW_OFS:  state_next.stillness_dwell_low = wr_data;
                STILLNESS_DWELL_HIGH_OFS: state_next.stillness_dwell_high = wr_data;
                default:                  state_next.standby = state_reg.standby;
            endcase
        end

        // keyed reset wins over all else this cycle
        if (wr_en && addr == SOFTWARE_RESET_KEY_OFS && wr_data == SOFT_RESET_KEY) begin
            state_next.motion_level_low = CONFIG_RESET_VALUE;
            state_next.motion_level_high = '0;
            state_next.motion_dwell = CONFIG_RESET_VALUE;
            state_next.stillness_level_low = CONFIG_RESET_VALUE;
            state_next.stillness_level_high = '0;
            state_next.stillness_dwell_low = CONFIG_RESET_VALUE;
            state_next.stillness_dwell_high = CONFIG_RESET_VALUE;
            state_next.motion_dwell_count = 8'h00;
            state_next.stillness_dwell_count = 16'h0000;
            state_next.motion_event = 1'b0;
            state_next.stillness_event = 1'b0;
            state_next.soft_reset_pulse = 1'b1;
            state_next.standby = 1'b1;
            state_next.int_pins_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.rd_data <= 8'h00;
            state_reg.queue <= QUEUE_RESET_VALUE;
            state_reg.x <= SAMPLE_RESET_VALUE;
            state_reg.y <= SAMPLE_RESET_VALUE;
            state_reg.z <= SAMPLE_RESET_VALUE;
            state_reg.thermal <= SAMPLE_RESET_VALUE;
            state_reg.motion_level_low <= CONFIG_RESET_VALUE;
            state_reg.motion_level_high <= '0;
            state_reg.motion_dwell <= CONFIG_RESET_VALUE;
            state_reg.stillness_level_low <= CONFIG_RESET_VALUE;
            state_reg.stillness_level_high <= '0;
            state_reg.stillness_dwell_low <= CONFIG_RESET_VALUE;
            state_reg.stillness_dwell_high <= CONFIG_RESET_VALUE;
            state_reg.motion_dwell_count <= 8'h00;
            state_reg.stillness_dwell_count <= 16'h0000;
            state_reg.motion_event <= 1'b0;
            state_reg.stillness_event <= 1'b0;
            state_reg.soft_reset_pulse <= 1'b0;
            state_reg.standby <= 1'b1;
            state_reg.int_pins_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.rd_data;
    assign motion_event = state_reg.motion_event;
    assign stillness_event = state_reg.stillness_event;
    assign soft_reset_pulse = state_reg.soft_reset_pulse;
    assign standby = state_reg.standby;
    assign int_pins_oe_n = state_reg.int_pins_oe_n;

endmodule

// >>> tb/motion_properties.sv
`timescale 1ns/100ps
module motion_checker
    import motion_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Register port
    input wire logic                wr_en,
    input wire logic                rd_en,
    input wire logic [ADDR_W-1:0]   addr,
    input wire logic [DATA_W-1:0]   wr_data,
    input wire logic [DATA_W-1:0]   rd_data,
    // Samples and detector control
    input wire logic                sample_strobe,
    input wire logic [SAMPLE_W-1:0] x_sample,
    input wire logic                motion_enable,
    input wire logic                stillness_enable,
    // Events and status
    input wire logic                motion_event,
    input wire logic                stillness_event,
    input wire logic                soft_reset_pulse,
    input wire logic                standby,
    input wire logic                int_pins_oe_n
);
    logic [DATA_W-1:0] x_hi_reg;

    // Expected high byte of the last x sample
    always_ff @(posedge clk) begin
        if (rst)
            x_hi_reg <= 8'h00;
        else if (sample_strobe)
            x_hi_reg <= {{4{x_sample[11]}}, x_sample[11:8]};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    key_reset_a: assert property (
        wr_en && addr == SOFTWARE_RESET_KEY_OFS && wr_data == SOFT_RESET_KEY |=> soft_reset_pulse && standby)
        else $error("keyed write gave no reset pulse");
    wrong_key_a: assert property (
        wr_en && addr == SOFTWARE_RESET_KEY_OFS && wr_data != SOFT_RESET_KEY |=> !soft_reset_pulse)
        else $error("wrong key caused a reset");
    pins_released_a: assert property (soft_reset_pulse |-> int_pins_oe_n)
        else $error("interrupt pins driven after keyed reset");
    key_read_a: assert property (rd_en && addr == SOFTWARE_RESET_KEY_OFS |=> rd_data == 8'h00)
        else $error("reset key register read not zero");
    x_sign_fill_a: assert property (rd_en && addr == X_SAMPLE_HIGH_OFS |=> rd_data == $past(x_hi_reg))
        else $error("x high byte wrong");
    motion_cause_a: assert property (motion_event |-> $past(sample_strobe) && $past(motion_enable))
        else $error("motion event without enabled strobe");
    motion_once_a: assert property (motion_event |=> !motion_event)
        else $error("motion event longer than one cycle");
    still_cause_a: assert property (stillness_event |-> $past(sample_strobe) && $past(stillness_enable))
        else $error("stillness event without enabled strobe");
    read_hold_a: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");
endmodule

bind motion_data_and_detect_regs motion_checker u_chk (
    .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .sample_strobe(sample_strobe), .x_sample(x_sample),
    .motion_enable(motion_enable), .stillness_enable(stillness_enable),
    .motion_event(motion_event), .stillness_event(stillness_event),
    .soft_reset_pulse(soft_reset_pulse), .standby(standby), .int_pins_oe_n(int_pins_oe_n)
);

// >>> tb/host_model.sv
`timescale 1ns/100ps
module host_model
    import motion_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register port
    output logic                   wr_en,
    output logic                   rd_en,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      wr_data,
    input  wire logic [DATA_W-1:0] rd_data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 6'h3f;
        wr_data = 8'h00;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        // Released lines must not look like the last value
        addr <= ~a;
        wr_data <= ~v;
        if (a == SOFTWARE_RESET_KEY_OFS && v == SOFT_RESET_KEY)
            repeat (SOFT_RESET_SETTLE_CYCLES) @(posedge clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1 v = rd_data;
    endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
    import motion_pkg::*;
    logic                clk, rst, wr_en, rd_en, sample_strobe, motion_enable, stillness_enable;
    logic                wakeup_mode, int_pins_claim, motion_event, stillness_event;
    logic                soft_reset_pulse, standby, int_pins_oe_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wr_data, rd_data, d;
    logic [SAMPLE_W-1:0] xs, ys, zs, ts;
    logic [QUEUE_W-1:0]  queue_count;
    logic [SAMPLE_W-1:0] smp [4] = '{12'h8a5, 12'h7f0, 12'h123, 12'hf01};
    int                  failures, comparisons;

    motion_data_and_detect_regs u_dut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .sample_strobe(sample_strobe), .x_sample(xs), .y_sample(ys),
        .z_sample(zs), .thermal_sample(ts), .queue_count(queue_count), .motion_enable(motion_enable),
        .stillness_enable(stillness_enable), .wakeup_mode(wakeup_mode), .int_pins_claim(int_pins_claim),
        .motion_event(motion_event), .stillness_event(stillness_event), .soft_reset_pulse(soft_reset_pulse),
        .standby(standby), .int_pins_oe_n(int_pins_oe_n));
    host_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .rd_data(rd_data));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        check(d, e);
    endtask

    task automatic strobe(input logic [11:0] x, y, z, input logic em, es);
        @(posedge clk);
        sample_strobe <= 1'b1;
        xs <= x;
        ys <= y;
        zs <= z;
        @(posedge clk);
        sample_strobe <= 1'b0;
        #1 check({7'h00, motion_event}, {7'h00, em});
        check({7'h00, stillness_event}, {7'h00, es});
    endtask

    task automatic give_verdict;
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Test span plus margin
    initial begin
        #(20 * 60000);
        failures++;
        give_verdict;
    end

    initial begin
        {rst, sample_strobe, motion_enable, stillness_enable, wakeup_mode, int_pins_claim} = 6'h20;
        {xs, ys, zs, ts, queue_count} = '0;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 'h0c; a <= 'h26; a++) rdc(6'(a), 8'h00);
        rdc(6'h3f, 8'h00);
        u_host.wr(X_SAMPLE_LOW_OFS, 8'h55);
        for (int i = 0; i < 7; i++) u_host.wr(6'h20 + 6'(i), 8'h9f - 8'(i));
        for (int i = 0; i < 7; i++) rdc(6'h20 + 6'(i), (8'h9f - 8'(i)) & ((i == 1 || i == 4) ? 8'h07 : 8'hff));
        queue_count <= 10'h200;
        ts <= smp[3];
        strobe(smp[0], smp[1], smp[2], 1'b0, 1'b0);
        rdc(QUEUE_COUNT_LOW_OFS, 8'h00);
        u_host.rd(QUEUE_COUNT_HIGH_OFS, d);
        check(d & 8'h03, 8'h02);
        for (int i = 0; i < 4; i++) begin
            rdc(6'h0e + 6'(2 * i), smp[i][7:0]);
            rdc(6'h0f + 6'(2 * i), {{4{smp[i][11]}}, smp[i][11:8]});
        end
        u_host.wr(MOTION_LEVEL_LOW_OFS, 8'h10);
        u_host.wr(MOTION_LEVEL_HIGH_OFS, 8'h00);
        u_host.wr(MOTION_DWELL_OFS, 8'h02);
        @(posedge clk) motion_enable <= 1'b1;
        strobe(12'hfe0, 12'h0, 12'h0, 1'b0, 1'b0);
        strobe(12'h010, 12'h0, 12'h0, 1'b0, 1'b0);
        strobe(12'h0, 12'h020, 12'h0, 1'b0, 1'b0);
        strobe(12'h0, 12'h0, 12'hfe0, 1'b1, 1'b0);
        strobe(12'h020, 12'h0, 12'h0, 1'b0, 1'b0);
        u_host.wr(MOTION_DWELL_OFS, 8'h00);
        strobe(12'h0, 12'h0, 12'h0, 1'b0, 1'b0);
        strobe(12'h800, 12'h0, 12'h0, 1'b1, 1'b0);
        u_host.wr(MOTION_DWELL_OFS, 8'h03);
        @(posedge clk) wakeup_mode <= 1'b1;
        strobe(12'h0, 12'h0, 12'h0, 1'b0, 1'b0);
        strobe(12'h0, 12'h0, 12'h7ff, 1'b1, 1'b0);
        @(posedge clk) {wakeup_mode, motion_enable, stillness_enable} <= 3'b001;
        u_host.wr(STILLNESS_LEVEL_LOW_OFS, 8'h10);
        u_host.wr(STILLNESS_LEVEL_HIGH_OFS, 8'h00);
        u_host.wr(STILLNESS_DWELL_LOW_OFS, 8'h02);
        u_host.wr(STILLNESS_DWELL_HIGH_OFS, 8'h01);
        strobe(12'h010, 12'h0, 12'h0, 1'b0, 1'b0);
        for (int i = 1; i <= 259; i++) strobe(12'h00f, 12'hff1, 12'h0, 1'b0, 1'(i == 258));
        u_host.wr(STILLNESS_DWELL_LOW_OFS, 8'h00);
        u_host.wr(STILLNESS_DWELL_HIGH_OFS, 8'h00);
        strobe(12'h0, 12'h0, 12'hff0, 1'b0, 1'b0);
        strobe(12'h00f, 12'h0, 12'h0, 1'b0, 1'b1);
        @(posedge clk) int_pins_claim <= 1'b1;
        @(posedge clk) int_pins_claim <= 1'b0;
        #1 check({7'h00, int_pins_oe_n}, 8'h00);
        u_host.wr(SOFTWARE_RESET_KEY_OFS, 8'h51);
        rdc(MOTION_DWELL_OFS, 8'h03);
        u_host.wr(SOFTWARE_RESET_KEY_OFS, SOFT_RESET_KEY);
        check({6'h00, int_pins_oe_n, standby}, 8'h03);
        for (int a = 'h20; a <= 'h26; a++) rdc(6'(a), 8'h00);
        rdc(X_SAMPLE_LOW_OFS, 8'h0f);
        rdc(SOFTWARE_RESET_KEY_OFS, 8'h00);
        give_verdict;
    end
endmodule
